/* File: rtl/rsma_pkg.sv */
// What this block does
// - Alert bit in status is set while any unmasked event is present.
// - Thermal-hot flag at bit five follows the thermal sense comparator.
// - Low-output flag at bit four sets after 200 us continuous undervoltage.
// - High-output flag at bit three follows the overvoltage or fixed-limit comparator.
// - Current flag at bit two sets when the valley current exceeds the alarm level.
// - Hard current limit sits 15 mV above the alarm level, alarm trips first.
// - Ceiling-error flag at bit one while target code exceeds the ceiling register.
// - Ceiling-error flag clears once the target code falls back to or below the ceiling.
// - Flags update regardless of the mask; mask only gates the alert.
// - Current flag is sticky but stops holding the alert once the condition ends.
// - Thermal, low, high and ceiling flags are live, never latched.
// - A status read clears the latched current flag; host reads status to learn cause.
// - Alert bit is the OR of gated flags five, four, three and one and the gated live current alarm, and drives the alert pin.
// - Each flag is gated by the inverse of its own mask bit.
// - Mask bits sit at flag positions five to one; bit zero and top two read zero.
// - Target writes above the ceiling are accepted; regulation uses the ceiling.
// - Top two status bits always read zero.
// - Serial access keeps working after a fault shutdown.
package rsma_pkg;
  localparam logic [7:0]  RSMA_CEILING_ADDR  = 8'h02;
  localparam logic [7:0]  RSMA_STATUS_ADDR   = 8'h04;
  localparam logic [7:0]  RSMA_MASK_ADDR     = 8'h05;
  localparam logic [7:0]  RSMA_TARGET_ADDR   = 8'h07;
  localparam logic [6:0]  RSMA_CEILING_RESET = 7'h51;
  localparam logic [7:0]  RSMA_MASK_RESET    = 8'h00;
  localparam logic [7:0]  RSMA_TARGET_RESET  = 8'h33;
  localparam int          RSMA_HOT_BIT       = 5;
  localparam int          RSMA_LOW_BIT       = 4;
  localparam int          RSMA_HIGH_BIT      = 3;
  localparam int          RSMA_CURRENT_BIT   = 2;
  localparam int          RSMA_CEILING_BIT   = 1;
  localparam int          RSMA_ALERT_BIT     = 0;
  localparam logic [7:0]  RSMA_MASK_BITS     = 8'h3e;
  localparam int          RSMA_CLK_MHZ       = 250;
  localparam int          RSMA_LOW_DELAY_US  = 200;
  localparam int          RSMA_LOW_DELAY_CYC = RSMA_LOW_DELAY_US * RSMA_CLK_MHZ;
  localparam int          RSMA_ALARM_MV      = 23;
  localparam int          RSMA_LIMIT_STEP_MV = 15;
  localparam int          RSMA_LIMIT_MV      = RSMA_ALARM_MV + RSMA_LIMIT_STEP_MV;
  localparam logic [6:0]  RSMA_SLAVE_ADDR    = 7'h70;
endpackage : rsma_pkg

/* File: rtl/rsma_sync.sv */
module rsma_sync
  import rsma_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : rsma_sync

/* File: rtl/rsma_filter.sv */
module rsma_filter
  import rsma_pkg::*;
#(
  parameter int DELAY_CYC = RSMA_LOW_DELAY_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Condition
  input  wire logic cond,
  output logic      qualified
);
  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_qualified;

  // Any gap restarts the count so short dips never qualify
  always_comb begin
    next_count     = '0;
    next_qualified = 1'b0;
    if (cond) begin
      if (count >= LAST) begin
        next_count     = count;
        next_qualified = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count     <= '0;
      qualified <= 1'b0;
    end else begin
      count     <= next_count;
      qualified <= next_qualified;
    end
  end
endmodule : rsma_filter

/* File: rtl/rsma_top.sv */
module rsma_top
  import rsma_pkg::*;
#(
  parameter int LOW_DELAY_CYC = RSMA_LOW_DELAY_CYC
) (
  // Clock and reset
  input  wire logic REF_CLK,
  input  wire logic RST_B,
  // Two-wire serial link
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE,
  // Analog comparator results
  input  wire logic THERMAL_SENSE_INPUT,
  input  wire logic UNDER_TARGET_IN,
  input  wire logic OVER_TARGET_IN,
  input  wire logic OVER_FIXED_LIMIT_IN,
  input  wire logic CURRENT_ALARM_IN,
  // Regulation
  output logic [6:0] REGULATED_CODE,
  // Alert pin, open drain
  output logic       ALERT_OUT,
  output logic       ALERT_OE
);
  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK, S_WDATA, S_WDATA_ACK,
                S_RDATA, S_RDATA_ACK, S_SKIP} rsma_state_type;

  logic scl;
  logic sda;
  logic [4:0] comp;
  logic under_low;

  rsma_sync #(.WIDTH(2)) u_link_sync (
    .clk      (REF_CLK),
    .rst_b    (RST_B),
    .async_in ({SCL_IN, SDA_IN}),
    .sync_out ({scl, sda})
  );

  rsma_sync #(.WIDTH(5)) u_comp_sync (
    .clk      (REF_CLK),
    .rst_b    (RST_B),
    .async_in ({THERMAL_SENSE_INPUT, UNDER_TARGET_IN, OVER_TARGET_IN, OVER_FIXED_LIMIT_IN, CURRENT_ALARM_IN}),
    .sync_out (comp)
  );

  rsma_filter #(.DELAY_CYC(LOW_DELAY_CYC)) u_low_filter (
    .clk       (REF_CLK),
    .rst_b     (RST_B),
    .cond      (comp[3]),
    .qualified (under_low)
  );

  // Link state
  rsma_state_type state;
  rsma_state_type next_state;
  logic       scl_d;
  logic       sda_d;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] bit_count;
  logic [3:0] next_bit_count;
  logic       rd_mode;
  logic       next_rd_mode;
  logic [7:0] reg_ptr;
  logic [7:0] next_reg_ptr;
  logic       next_sda_oe;

  // Register state
  logic [6:0] voltage_ceiling;
  logic [6:0] next_voltage_ceiling;
  logic [7:0] status_mask;
  logic [7:0] next_status_mask;
  logic [7:0] target_voltage_code;
  logic [7:0] next_target_voltage_code;
  logic       current_sticky;
  logic       next_current_sticky;
  logic       next_alert_oe;
  logic [6:0] next_regulated_code;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       wr_strobe;
  logic       status_read;
  logic [7:0] regulator_status;
  logic [5:1] gated;
  logic       thermal_hot_flag;
  logic       low_output_flag;
  logic       high_output_flag;
  logic       current_limit_flag;
  logic       ceiling_error_flag;
  logic       alert_n;
  logic [7:0] read_data;

  always_comb begin
    scl_rise   = scl & ~scl_d;
    scl_fall   = ~scl & scl_d;
    start_cond = scl & scl_d & sda_d & ~sda;
    stop_cond  = scl & scl_d & ~sda_d & sda;
  end

  // Flags come from conditions regardless of mask; the current flag is the sticky latch
  always_comb begin
    thermal_hot_flag   = comp[4];
    low_output_flag    = under_low;
    high_output_flag   = comp[2] | comp[1];
    current_limit_flag = current_sticky;
    ceiling_error_flag = target_voltage_code > {1'b0, voltage_ceiling};
    // Sticky flag only feeds the alert while the alarm is still live
    gated[RSMA_HOT_BIT]     = thermal_hot_flag & ~status_mask[RSMA_HOT_BIT];
    gated[RSMA_LOW_BIT]     = low_output_flag & ~status_mask[RSMA_LOW_BIT];
    gated[RSMA_HIGH_BIT]    = high_output_flag & ~status_mask[RSMA_HIGH_BIT];
    gated[RSMA_CURRENT_BIT] = comp[0] & ~status_mask[RSMA_CURRENT_BIT];
    gated[RSMA_CEILING_BIT] = ceiling_error_flag & ~status_mask[RSMA_CEILING_BIT];
    alert_n = ~(|gated);
    regulator_status = {2'b00, thermal_hot_flag, low_output_flag, high_output_flag,
                        current_limit_flag, ceiling_error_flag, ~alert_n};
  end

  always_comb begin
    read_data = 8'h00;
    if (reg_ptr == RSMA_CEILING_ADDR) begin
      read_data = {1'b0, voltage_ceiling};
    end else if (reg_ptr == RSMA_STATUS_ADDR) begin
      read_data = regulator_status;
    end else if (reg_ptr == RSMA_MASK_ADDR) begin
      read_data = status_mask & RSMA_MASK_BITS;
    end else if (reg_ptr == RSMA_TARGET_ADDR) begin
      read_data = target_voltage_code;
    end
  end

  // Serial slave; runs independent of regulator shutdown
  always_comb begin
    next_state     = state;
    next_shift     = shift;
    next_bit_count = bit_count;
    next_rd_mode   = rd_mode;
    next_reg_ptr   = reg_ptr;
    next_sda_oe    = SDA_OE;
    wr_strobe      = 1'b0;
    status_read    = 1'b0;
    if (start_cond) begin
      next_state     = S_ADDR;
      next_bit_count = 4'h0;
      next_sda_oe    = 1'b0;
    end else if (stop_cond) begin
      next_state  = S_IDLE;
      next_sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (state == S_ADDR || state == S_REG || state == S_WDATA) begin
        next_shift     = {shift[6:0], sda};
        next_bit_count = bit_count + 4'h1;
      end else if (state == S_RDATA_ACK && sda) begin
        next_state = S_SKIP;
      end
    end else if (scl_fall) begin
      case (state)
        S_ADDR: begin
          if (bit_count == 4'h8) begin
            if (shift[7:1] == RSMA_SLAVE_ADDR) begin
              next_state   = S_ADDR_ACK;
              next_rd_mode = shift[0];
              next_sda_oe  = 1'b1;
            end else begin
              next_state = S_SKIP;
            end
          end
        end
        S_ADDR_ACK: begin
          next_bit_count = 4'h0;
          if (rd_mode) begin
            next_state  = S_RDATA;
            next_shift  = read_data;
            next_sda_oe = ~read_data[7];
            status_read = reg_ptr == RSMA_STATUS_ADDR;
          end else begin
            next_state  = S_REG;
            next_sda_oe = 1'b0;
          end
        end
        S_REG: begin
          if (bit_count == 4'h8) begin
            next_state   = S_REG_ACK;
            next_reg_ptr = shift;
            next_sda_oe  = 1'b1;
          end
        end
        S_REG_ACK, S_WDATA_ACK: begin
          next_state     = S_WDATA;
          next_bit_count = 4'h0;
          next_sda_oe    = 1'b0;
        end
        S_WDATA: begin
          if (bit_count == 4'h8) begin
            next_state  = S_WDATA_ACK;
            wr_strobe   = 1'b1;
            next_sda_oe = 1'b1;
          end
        end
        S_RDATA: begin
          next_bit_count = bit_count + 4'h1;
          if (bit_count == 4'h7) begin
            next_state  = S_RDATA_ACK;
            next_sda_oe = 1'b0;
          end else begin
            next_shift  = {shift[6:0], 1'b0};
            next_sda_oe = ~shift[6];
          end
        end
        S_RDATA_ACK: begin
          next_state     = S_RDATA;
          next_bit_count = 4'h0;
          next_shift     = read_data;
          next_sda_oe    = ~read_data[7];
          status_read    = reg_ptr == RSMA_STATUS_ADDR;
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    next_voltage_ceiling     = voltage_ceiling;
    next_status_mask         = status_mask;
    next_target_voltage_code = target_voltage_code;
    if (wr_strobe) begin
      if (reg_ptr == RSMA_CEILING_ADDR) begin
        next_voltage_ceiling = shift[6:0];
      end else if (reg_ptr == RSMA_MASK_ADDR) begin
        next_status_mask = shift & RSMA_MASK_BITS;
      end else if (reg_ptr == RSMA_TARGET_ADDR) begin
        next_target_voltage_code = shift;
      end
    end
    // A new event in the read cycle wins over the clear
    next_current_sticky = (current_sticky & ~status_read) | comp[0];
    next_alert_oe       = ~alert_n;
    // Above-ceiling targets are held at the ceiling
    if (target_voltage_code > {1'b0, voltage_ceiling}) begin
      next_regulated_code = voltage_ceiling;
    end else begin
      next_regulated_code = target_voltage_code[6:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      state               <= S_IDLE;
      scl_d               <= 1'b1;
      sda_d               <= 1'b1;
      shift               <= 8'h00;
      bit_count           <= 4'h0;
      rd_mode             <= 1'b0;
      reg_ptr             <= 8'h00;
      SDA_OE              <= 1'b0;
      voltage_ceiling     <= RSMA_CEILING_RESET;
      status_mask         <= RSMA_MASK_RESET;
      target_voltage_code <= RSMA_TARGET_RESET;
      current_sticky      <= 1'b0;
      ALERT_OE            <= 1'b0;
      REGULATED_CODE      <= RSMA_TARGET_RESET[6:0];
    end else begin
      state               <= next_state;
      scl_d               <= scl;
      sda_d               <= sda;
      shift               <= next_shift;
      bit_count           <= next_bit_count;
      rd_mode             <= next_rd_mode;
      reg_ptr             <= next_reg_ptr;
      SDA_OE              <= next_sda_oe;
      voltage_ceiling     <= next_voltage_ceiling;
      status_mask         <= next_status_mask;
      target_voltage_code <= next_target_voltage_code;
      current_sticky      <= next_current_sticky;
      ALERT_OE            <= next_alert_oe;
      REGULATED_CODE      <= next_regulated_code;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge REF_CLK) begin
    SDA_OUT   <= 1'b0;
    ALERT_OUT <= 1'b0;
  end
endmodule : rsma_top

/* File: dv/rsma_monitor.sv */
module rsma_monitor
  import rsma_pkg::*;
#(
  parameter int LOW_DELAY_CYC = RSMA_LOW_DELAY_CYC
) (
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       RST_B,
  // Serial link
  input wire logic       SCL_IN,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  // Comparators
  input wire logic       THERMAL_SENSE_INPUT,
  input wire logic       UNDER_TARGET_IN,
  input wire logic       OVER_TARGET_IN,
  input wire logic       OVER_FIXED_LIMIT_IN,
  input wire logic       CURRENT_ALARM_IN,
  // Outputs
  input wire logic [6:0] REGULATED_CODE,
  input wire logic       ALERT_OUT,
  input wire logic       ALERT_OE
);
  logic [6:0]  pins;
  logic [6:0]  last_pins;
  logic [6:0]  next_last_pins;
  logic [31:0] quiet;
  logic [31:0] next_quiet;
  assign pins = {SCL_IN, SDA_IN, THERMAL_SENSE_INPUT, UNDER_TARGET_IN, OVER_TARGET_IN,
                 OVER_FIXED_LIMIT_IN, CURRENT_ALARM_IN};
  // Cycles since any input moved; bus activity may legally change state
  always_comb begin
    next_last_pins = pins;
    if (!RST_B || pins != last_pins || !SCL_IN) begin
      next_quiet = 32'h0;
    end else begin
      next_quiet = quiet + 32'h1;
    end
  end
  always_ff @(posedge REF_CLK) begin
    quiet     <= next_quiet;
    last_pins <= next_last_pins;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sda_low_a: assert property (SDA_OUT == 1'b0) else $error("data pin driven high");
  alert_low_a: assert property (ALERT_OUT == 1'b0) else $error("alert pin driven high");
  ack_change_a: assert property ($changed(SDA_OE) |-> !SCL_IN) else $error("data moved with clock high");
  data_hold_a: assert property (SCL_IN [*4] |-> $stable(SDA_OE)) else $error("data not held");
  ack_answer_a: assert property ($rose(SDA_OE) |-> $past(SCL_IN, 10)) else $error("late answer");
  alert_idle_a: assert property (quiet > LOW_DELAY_CYC + 4 |-> $stable(ALERT_OE))
    else $error("alert moved without cause");
  alert_fall_a: assert property ($fell(ALERT_OE) |-> quiet < 8) else $error("alert release late");
  alert_rise_a: assert property ($rose(ALERT_OE) |-> quiet < LOW_DELAY_CYC + 8)
    else $error("alert raised without cause");
  code_idle_a: assert property (quiet > 8 |-> $stable(REGULATED_CODE)) else $error("code moved idle");
endmodule : rsma_monitor

bind rsma_top rsma_monitor #(.LOW_DELAY_CYC(LOW_DELAY_CYC)) mon_u (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .THERMAL_SENSE_INPUT(THERMAL_SENSE_INPUT), .UNDER_TARGET_IN(UNDER_TARGET_IN),
  .OVER_TARGET_IN(OVER_TARGET_IN), .OVER_FIXED_LIMIT_IN(OVER_FIXED_LIMIT_IN),
  .CURRENT_ALARM_IN(CURRENT_ALARM_IN), .REGULATED_CODE(REGULATED_CODE), .ALERT_OUT(ALERT_OUT),
  .ALERT_OE(ALERT_OE));

/* File: dv/rsma_host.sv */
module rsma_host
  import rsma_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Bus pins
  output logic      scl,
  output logic      sda,
  input  wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull;
  // Pull-up wins unless someone pulls low
  assign sda = !(pull || sda_oe);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // Clock stands high between frames
  task automatic bit_io(input logic b, output logic s);
    pull = !b;
    wt(10);
    scl = 1'b1;
    wt(20);
    s = sda;
    scl = 1'b0;
    wt(10);
  endtask : bit_io
  task automatic start();
    pull = 1'b0;
    wt(10);
    scl = 1'b1;
    wt(10);
    pull = 1'b1;
    wt(10);
    scl = 1'b0;
    wt(10);
  endtask : start
  task automatic stop();
    pull = 1'b1;
    wt(10);
    scl = 1'b1;
    wt(10);
    pull = 1'b0;
    wt(10);
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask : xfer
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       k1;
    logic       k2;
    logic       k3;
    start();
    xfer({RSMA_SLAVE_ADDR, 1'b0}, 1'b1, rx, k1);
    xfer(a, 1'b1, rx, k2);
    xfer(d, 1'b1, rx, k3);
    stop();
    ok = !(k1 | k2 | k3);
  endtask : reg_write
  // Status read is how the host learns the cause
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] rx;
    logic       k;
    start();
    xfer({RSMA_SLAVE_ADDR, 1'b0}, 1'b1, rx, k);
    xfer(a, 1'b1, rx, k);
    start();
    xfer({RSMA_SLAVE_ADDR, 1'b1}, 1'b1, rx, k);
    xfer(8'hff, 1'b1, d, k);
    stop();
  endtask : reg_read
endmodule : rsma_host

/* File: dv/regulator_status_mask_alert_test.sv */
module regulator_status_mask_alert_test
  import rsma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short filter keeps the run brief
  localparam int LOW = 20;
  logic       clk;
  logic       rst_b;
  logic       scl;
  logic       sda;
  logic       sda_oe;
  logic [4:0] cmp;
  logic [6:0] code;
  logic       alert_oe;
  int         failures;
  int         n_tests;
  rsma_top #(.LOW_DELAY_CYC(LOW)) dut_u (
    .REF_CLK(clk), .RST_B(rst_b), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .THERMAL_SENSE_INPUT(cmp[4]), .UNDER_TARGET_IN(cmp[3]), .OVER_TARGET_IN(cmp[2]),
    .OVER_FIXED_LIMIT_IN(cmp[1]), .CURRENT_ALARM_IN(cmp[0]), .REGULATED_CODE(code),
    .ALERT_OUT(), .ALERT_OE(alert_oe));
  rsma_host host_u (.clk(clk), .scl(scl), .sda(sda), .sda_oe(sda_oe));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.reg_read(a, d);
    check(d, exp);
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host_u.reg_write(a, d, ok);
    check({7'h0, ok}, 8'h01);
  endtask : wr
  task automatic t_reset();
    rd_chk(RSMA_CEILING_ADDR, 8'h51);
    rd_chk(RSMA_STATUS_ADDR, 8'h00);
    rd_chk(8'h03, 8'h00);
    check({1'b0, code}, 8'h33);
    wr(RSMA_MASK_ADDR, 8'hff);
    rd_chk(RSMA_MASK_ADDR, 8'h3e);
    wr(RSMA_MASK_ADDR, 8'h00);
    $display("reset and mask done");
  endtask : t_reset
  task automatic t_flags();
    logic [7:0] bitv;
    cmp = 5'h08;
    repeat (LOW - 5) @(negedge clk);
    cmp = 5'h00;
    rd_chk(RSMA_STATUS_ADDR, 8'h00);
    for (int i = 1; i < 5; i++) begin
      bitv = 8'h01 << (i == 1 ? 3 : i + 1);
      cmp = 5'h01 << i;
      repeat (LOW + 10) @(negedge clk);
      check({7'h0, alert_oe}, 8'h01);
      rd_chk(RSMA_STATUS_ADDR, bitv | 8'h01);
      wr(RSMA_MASK_ADDR, bitv);
      check({7'h0, alert_oe}, 8'h00);
      rd_chk(RSMA_STATUS_ADDR, bitv);
      cmp = 5'h00;
      wr(RSMA_MASK_ADDR, 8'h00);
      rd_chk(RSMA_STATUS_ADDR, 8'h00);
    end
    $display("live flags done");
  endtask : t_flags
  task automatic t_current();
    cmp = 5'h01;
    repeat (10) @(negedge clk);
    check({7'h0, alert_oe}, 8'h01);
    wr(RSMA_MASK_ADDR, 8'h04);
    check({7'h0, alert_oe}, 8'h00);
    // Read while the alarm is live: the set must win over the clear
    rd_chk(RSMA_STATUS_ADDR, 8'h04);
    wr(RSMA_MASK_ADDR, 8'h00);
    check({7'h0, alert_oe}, 8'h01);
    cmp = 5'h00;
    repeat (10) @(negedge clk);
    check({7'h0, alert_oe}, 8'h00);
    rd_chk(RSMA_STATUS_ADDR, 8'h04);
    rd_chk(RSMA_STATUS_ADDR, 8'h00);
    $display("sticky current done");
  endtask : t_current
  task automatic t_ceiling();
    wr(RSMA_TARGET_ADDR, 8'h52);
    check({7'h0, alert_oe}, 8'h01);
    rd_chk(RSMA_TARGET_ADDR, 8'h52);
    rd_chk(RSMA_STATUS_ADDR, 8'h03);
    wr(RSMA_MASK_ADDR, 8'h02);
    check({7'h0, alert_oe}, 8'h00);
    rd_chk(RSMA_STATUS_ADDR, 8'h02);
    wr(RSMA_MASK_ADDR, 8'h00);
    check({1'b0, code}, 8'h51);
    wr(RSMA_CEILING_ADDR, 8'hff);
    rd_chk(RSMA_CEILING_ADDR, 8'h7f);
    check({1'b0, code}, 8'h52);
    rd_chk(RSMA_STATUS_ADDR, 8'h00);
    wr(RSMA_CEILING_ADDR, 8'h51);
    rd_chk(RSMA_STATUS_ADDR, 8'h03);
    wr(RSMA_TARGET_ADDR, 8'h50);
    rd_chk(RSMA_STATUS_ADDR, 8'h00);
    check({1'b0, code}, 8'h50);
    $display("ceiling done");
  endtask : t_ceiling
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    cmp = 5'h00;
    failures = 0;
    n_tests = 0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_flags();
    t_current();
    t_ceiling();
    wrap_up();
  end
  // Expected run is near 62700 cycles
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule : regulator_status_mask_alert_test
